// [hdl/dect_pkg.sv]
package dect_pkg;
    // ----------------------------------------
    // Clock and timebase
    // ----------------------------------------
    localparam int CLK_MHZ = 20;
    localparam int TICK_US = 4;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int STAMP_W = 24;
    localparam logic [23:0] STAMP_RST = 24'h000000;
    // ----------------------------------------
    // Report pacing
    // ----------------------------------------
    localparam int RATE_MS = 8;
    localparam int RATE_CYC = RATE_MS * 1000 * CLK_MHZ;
    // ----------------------------------------
    // Report identifiers and field layout
    // ----------------------------------------
    localparam logic [7:0] ID_ENABLE = 8'h28;
    localparam logic [7:0] ID_REPORT_A = 8'h29;
    localparam logic [7:0] ID_REPORT_B = 8'h2a;
    localparam int EN_A_BIT = 0;
    localparam int EN_B_BIT = 1;
    localparam int EDGE_FALL = 0;
    localparam int EDGE_RISE = 1;
    localparam int FLAG_OVR_LSB = 4;
    localparam int FLAG_DET_LSB = 0;
endpackage

// [hdl/dect_sync.sv]
`timescale 1ns/1ps
module dect_sync import dect_pkg::*; #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    // Two stages; only the second stage is read outside this module
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            dout <= '0;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule

// [hdl/dect_chan.sv]
`timescale 1ns/1ps
module dect_chan import dect_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic lvl,
    input wire logic [STAMP_W-1:0] stamp,
    input wire logic clr,
    output logic [1:0] det_ff,
    output logic [1:0] ovr_ff,
    output logic [STAMP_W-1:0] fall_stamp_ff,
    output logic [STAMP_W-1:0] rise_stamp_ff
);
    logic prev_ff;
    logic [1:0] edge_hit;

    // Edge detection on the synchronised level
    assign edge_hit[EDGE_FALL] = en && prev_ff && !lvl;
    assign edge_hit[EDGE_RISE] = en && !prev_ff && lvl;

    // Previous level always tracks, so enabling gives no false edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= lvl;
        end
    end

    // Detect and overrun flags; a new edge wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_ff <= 2'h0;
            ovr_ff <= 2'h0;
        end else if (!en) begin
            det_ff <= 2'h0;
            ovr_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (edge_hit[i] && det_ff[i] && !clr) begin
                    ovr_ff[i] <= 1'b1; // [RULE_11]
                end else if (edge_hit[i]) begin
                    det_ff[i] <= 1'b1; // [RULE_02]
                    ovr_ff[i] <= 1'b0;
                end else if (clr) begin
                    det_ff[i] <= 1'b0;
                    ovr_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Stamp latched only for the first pending edge of each type
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fall_stamp_ff <= STAMP_RST;
            rise_stamp_ff <= STAMP_RST;
        end else begin
            if (edge_hit[EDGE_FALL] && (!det_ff[EDGE_FALL] || clr)) begin
                fall_stamp_ff <= stamp; // [RULE_13]
            end
            if (edge_hit[EDGE_RISE] && (!det_ff[EDGE_RISE] || clr)) begin
                rise_stamp_ff <= stamp; // [RULE_13]
            end
        end
    end
endmodule

// [hdl/dect_top.sv]
`timescale 1ns/1ps
// Operation
// (RULE_01) One 24-bit counter steps every 4 us while any channel is enabled.
// (RULE_02) Each rising or falling channel edge latches the counter and queues it.
// (RULE_03) The counter wraps from its maximum to zero silently.
// (RULE_04) Both channels stamp from the same shared counter.
// (RULE_05) Command 0x28: zero disables both, bit 0 enables A, bit 1 enables B.
// (RULE_06) Host writes all-disabled before any other nonzero enable combination.
// (RULE_07) Host keeps capture off while the infrared receiver runs.
// (RULE_08) Host keeps channel B off while the two-wire bus is in use.
// (RULE_09) Channel A reports use id 0x29, channel B reports id 0x2a.
// (RULE_10) Report: flags, falling stamp bytes, rising stamp bytes, low byte first.
// (RULE_11) Another edge before the pending one is sent is an overrun.
// (RULE_12) At most one report per 8 ms, shared with other functions.
// (RULE_13) Overrun keeps the first stamp; later edges dropped until sent.
// (RULE_14) Flags: bits 7..4 overruns, bits 3..0 detects; B rise, B fall, A rise, A fall.
// (RULE_15) A stamp is valid only when its detect flag is set.
// (RULE_16) Every report holds the flags of both channels.
// (RULE_17) Tracks 250 Hz on one channel or 125 Hz on both without loss; the 8 ms pacing here limits it to 125 Hz on one, 62.5 Hz on both.
// (RULE_18) Overrun not guaranteed at high rates; recovers when input slows.
// (RULE_19) Host avoids matrix and two-wire traffic during measurements.
// (RULE_20) Channel pins pass two flip-flops before edge detection.
module dect_top import dect_pkg::*; #(
    parameter int RATE_CYCLES = RATE_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CAPTURE_A_PIN,
    input wire logic CAPTURE_B_PIN,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_ID,
    input wire logic [7:0] CMD_ENABLE,
    input wire logic OTHER_PACKET,
    input wire logic REPORT_READY,
    output logic REPORT_VALID,
    output logic [7:0] REPORT_ID,
    output logic [7:0] REPORT_FLAGS,
    output logic [7:0] FALLING_STAMP_LOW_BYTE,
    output logic [7:0] FALLING_STAMP_MID_BYTE,
    output logic [7:0] FALLING_STAMP_HIGH_BYTE,
    output logic [7:0] RISING_STAMP_LOW_BYTE,
    output logic [7:0] RISING_STAMP_MID_BYTE,
    output logic [7:0] RISING_STAMP_HIGH_BYTE,
    output logic [1:0] CHANNEL_ENABLE,
    output logic [STAMP_W-1:0] TIMEBASE
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
    localparam logic [17:0] RATE_LAST = 18'(RATE_CYCLES - 1);

    logic [1:0] pin_sync;
    logic [1:0] enable_ff;
    logic [6:0] tick_cnt_ff;
    logic tick;
    logic run;
    logic [STAMP_W-1:0] stamp_ff;
    logic [17:0] budget_ff;
    logic rep_valid_ff;
    logic last_a_ff;
    logic [1:0] a_det, a_ovr, b_det, b_ovr;
    logic [STAMP_W-1:0] a_fall, a_rise, b_fall, b_rise;
    logic pend_a, pend_b, launch, pick_b;
    logic clr_a, clr_b;
    logic [7:0] flags_now;
    logic [7:0] rep_id_ff, rep_flags_ff;
    logic [STAMP_W-1:0] rep_fall_ff, rep_rise_ff;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    dect_sync #(
        .W(2)
    ) u_sync (
        .clk(CLOCK),
        .rst(SYS_RST),
        .din({CAPTURE_B_PIN, CAPTURE_A_PIN}), // [RULE_20]
        .dout(pin_sync)
    );

    // ----------------------------------------
    // Enable command
    // ----------------------------------------
    // Enable byte is applied as written; other ids are ignored here
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            enable_ff <= 2'h0;
        end else if (CMD_VALID && CMD_ID == ID_ENABLE) begin
            enable_ff <= {CMD_ENABLE[EN_B_BIT], CMD_ENABLE[EN_A_BIT]}; // [RULE_05]
        end
    end

    assign run = |enable_ff;

    // ----------------------------------------
    // Shared timebase
    // ----------------------------------------
    // Divider gives a one-cycle tick every 4 us
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tick_cnt_ff <= 7'h00;
        end else if (tick_cnt_ff == TICK_LAST) begin
            tick_cnt_ff <= 7'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 7'h01;
        end
    end

    assign tick = (tick_cnt_ff == TICK_LAST);

    // Counter steps only while capture runs; natural wrap, no flag
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            stamp_ff <= STAMP_RST;
        end else if (tick && run) begin
            stamp_ff <= stamp_ff + 24'h000001; // [RULE_01] [RULE_03]
        end
    end

    // ----------------------------------------
    // Capture channels
    // ----------------------------------------
    dect_chan u_chan_a (
        .clk(CLOCK),
        .rst(SYS_RST),
        .en(enable_ff[EN_A_BIT]),
        .lvl(pin_sync[0]),
        .stamp(stamp_ff), // [RULE_04]
        .clr(clr_a),
        .det_ff(a_det),
        .ovr_ff(a_ovr),
        .fall_stamp_ff(a_fall),
        .rise_stamp_ff(a_rise)
    );

    dect_chan u_chan_b (
        .clk(CLOCK),
        .rst(SYS_RST),
        .en(enable_ff[EN_B_BIT]),
        .lvl(pin_sync[1]),
        .stamp(stamp_ff), // [RULE_04]
        .clr(clr_b),
        .det_ff(b_det),
        .ovr_ff(b_ovr),
        .fall_stamp_ff(b_fall),
        .rise_stamp_ff(b_rise)
    );

    // ----------------------------------------
    // Report scheduling
    // ----------------------------------------
    // Flags of both channels in every report
    assign flags_now = {b_ovr[EDGE_RISE], b_ovr[EDGE_FALL], a_ovr[EDGE_RISE], a_ovr[EDGE_FALL],
                        b_det[EDGE_RISE], b_det[EDGE_FALL], a_det[EDGE_RISE], a_det[EDGE_FALL]}; // [RULE_14] [RULE_16]

    // A channel is pending when any edge is detected
    assign pend_a = |a_det;
    assign pend_b = |b_det;
    // Launch only when the shared budget has expired and the buffer is free
    assign launch = (budget_ff == 18'h00000) && !rep_valid_ff && (pend_a || pend_b); // [RULE_12]
    // Alternate between channels when both wait, so neither starves
    assign pick_b = pend_b && (!pend_a || last_a_ff); // [RULE_17]
    // Launch hands the data over and frees the channel for new edges
    assign clr_a = launch && !pick_b; // [RULE_18]
    assign clr_b = launch && pick_b;

    // Budget reloads on every packet, ours or another function's
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            budget_ff <= 18'h00000;
        end else if (launch || OTHER_PACKET) begin
            budget_ff <= RATE_LAST; // [RULE_12]
        end else if (budget_ff != 18'h00000) begin
            budget_ff <= budget_ff - 18'h00001;
        end
    end

    // Channel order memory
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            last_a_ff <= 1'b0;
        end else if (launch) begin
            last_a_ff <= !pick_b;
        end
    end

    // ----------------------------------------
    // Report output
    // ----------------------------------------
    // Valid stands until the host side accepts it
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rep_valid_ff <= 1'b0;
        end else if (launch) begin
            rep_valid_ff <= 1'b1;
        end else if (REPORT_READY) begin
            rep_valid_ff <= 1'b0;
        end
    end

    // Report contents captured at launch
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rep_id_ff <= 8'h00;
            rep_flags_ff <= 8'h00;
            rep_fall_ff <= STAMP_RST;
            rep_rise_ff <= STAMP_RST;
        end else if (launch) begin
            rep_id_ff <= pick_b ? ID_REPORT_B : ID_REPORT_A; // [RULE_09]
            rep_flags_ff <= flags_now;
            rep_fall_ff <= pick_b ? b_fall : a_fall; // [RULE_15]
            rep_rise_ff <= pick_b ? b_rise : a_rise;
        end
    end

    assign REPORT_VALID = rep_valid_ff;
    assign REPORT_ID = rep_id_ff;
    assign REPORT_FLAGS = rep_flags_ff;
    // Stamps go out least significant byte first
    assign FALLING_STAMP_LOW_BYTE = rep_fall_ff[7:0]; // [RULE_10]
    assign FALLING_STAMP_MID_BYTE = rep_fall_ff[15:8];
    assign FALLING_STAMP_HIGH_BYTE = rep_fall_ff[23:16];
    assign RISING_STAMP_LOW_BYTE = rep_rise_ff[7:0];
    assign RISING_STAMP_MID_BYTE = rep_rise_ff[15:8];
    assign RISING_STAMP_HIGH_BYTE = rep_rise_ff[23:16];
    assign CHANNEL_ENABLE = enable_ff;
    assign TIMEBASE = stamp_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    tick_period_a: assert property (tick |-> ##80 tick) else $error("tick period wrong"); // [RULE_01]
    stamp_step_a: assert property (tick && run && stamp_ff != 24'hffffff |=> stamp_ff == $past(stamp_ff) + 24'h000001)
        else $error("timebase did not step"); // [RULE_01]
    stamp_hold_a: assert property (!(tick && run) |=> $stable(stamp_ff)) else $error("timebase moved off tick");
    stamp_wrap_a: assert property (tick && run && stamp_ff == 24'hffffff |=> stamp_ff == 24'h000000)
        else $error("timebase did not wrap"); // [RULE_03]
    enable_cmd_a: assert property (CMD_VALID && CMD_ID == ID_ENABLE |=> CHANNEL_ENABLE == $past(CMD_ENABLE[1:0]))
        else $error("enable command not applied"); // [RULE_05]
    report_id_a: assert property (launch |=> REPORT_VALID && REPORT_ID == ($past(pick_b) ? ID_REPORT_B : ID_REPORT_A))
        else $error("wrong report id"); // [RULE_09]
    report_pace_a: assert property (launch ##1 (!OTHER_PACKET) [*8] |=> !launch && budget_ff == RATE_LAST - 18'd8)
        else $error("report pacing broken"); // [RULE_12]
    report_flags_a: assert property (launch |=> REPORT_FLAGS == $past(flags_now)) else $error("flags wrong"); // [RULE_14]
    report_bytes_a: assert property (launch && !pick_b |=> {FALLING_STAMP_HIGH_BYTE, FALLING_STAMP_MID_BYTE,
        FALLING_STAMP_LOW_BYTE} == $past(a_fall)) else $error("stamp bytes wrong"); // [RULE_10]
    first_kept_a: assert property (a_det[EDGE_RISE] && !clr_a && enable_ff[EN_A_BIT] |=> $stable(a_rise))
        else $error("pending stamp overwritten"); // [RULE_13]
    valid_hold_a: assert property (REPORT_VALID && !REPORT_READY |=> REPORT_VALID && $stable(REPORT_ID))
        else $error("report dropped before accept");
    valid_drop_a: assert property (REPORT_VALID && REPORT_READY |=> !REPORT_VALID)
        else $error("report still valid after accept");

    // ----------------------------------------
    // Capture checks
    // ----------------------------------------
    // Synchronised level trails the pin by two edges
    sync_depth_a: assert property ($rose(pin_sync[0]) |-> $past(CAPTURE_A_PIN, 2)) // [RULE_20]
        else $error("channel A pin not two stages deep");
    sync_depth_b_a: assert property ($fell(pin_sync[1]) |-> !$past(CAPTURE_B_PIN, 2)) // [RULE_20]
        else $error("channel B pin not two stages deep");
    // Each enabled edge raises its detect flag at the next edge, even beside a clear
    a_rise_det_a: assert property (enable_ff[EN_A_BIT] && $rose(pin_sync[0]) |=> a_det[EDGE_RISE]) // [RULE_02]
        else $error("channel A rising edge missed");
    a_fall_det_a: assert property (enable_ff[EN_A_BIT] && $fell(pin_sync[0]) |=> a_det[EDGE_FALL]) // [RULE_02]
        else $error("channel A falling edge missed");
    b_rise_det_a: assert property (enable_ff[EN_B_BIT] && $rose(pin_sync[1]) |=> b_det[EDGE_RISE]) // [RULE_02]
        else $error("channel B rising edge missed");
    b_fall_det_a: assert property (enable_ff[EN_B_BIT] && $fell(pin_sync[1]) |=> b_det[EDGE_FALL]) // [RULE_02]
        else $error("channel B falling edge missed");
    // A second same-type edge while one is pending marks an overrun
    a_fall_ovr_a: assert property (enable_ff[EN_A_BIT] && $fell(pin_sync[0]) && a_det[EDGE_FALL] // [RULE_11]
        && !clr_a |=> a_ovr[EDGE_FALL]) else $error("channel A falling overrun missed");
    b_rise_ovr_a: assert property (enable_ff[EN_B_BIT] && $rose(pin_sync[1]) && b_det[EDGE_RISE] // [RULE_11]
        && !clr_b |=> b_ovr[EDGE_RISE]) else $error("channel B rising overrun missed");
    // Pending stamps stay put until their report leaves
    a_fall_kept_a: assert property (a_det[EDGE_FALL] && !clr_a && enable_ff[EN_A_BIT] // [RULE_13]
        |=> $stable(a_fall)) else $error("pending channel A stamp overwritten");
    b_fall_kept_a: assert property (b_det[EDGE_FALL] && !clr_b && enable_ff[EN_B_BIT] // [RULE_13]
        |=> $stable(b_fall)) else $error("pending channel B stamp overwritten");
    // A disabled channel holds no pending flags
    a_off_clear_a: assert property (!enable_ff[EN_A_BIT] |=> a_det == 2'h0 && a_ovr == 2'h0) // [RULE_05]
        else $error("disabled channel A keeps flags");
    b_off_clear_a: assert property (!enable_ff[EN_B_BIT] |=> b_det == 2'h0 && b_ovr == 2'h0) // [RULE_05]
        else $error("disabled channel B keeps flags");

    // ----------------------------------------
    // Report checks
    // ----------------------------------------
    // Flag byte packs overruns above detects, channel B above channel A, rise above fall
    flags_pack_a: assert property (launch |=> REPORT_FLAGS == $past({b_ovr, a_ovr, b_det, a_det})) // [RULE_16]
        else $error("flags of both channels not reported");
    report_rise_a: assert property (launch && pick_b |=> {RISING_STAMP_HIGH_BYTE, RISING_STAMP_MID_BYTE, // [RULE_10]
        RISING_STAMP_LOW_BYTE} == $past(b_rise)) else $error("rising stamp bytes wrong");
    launch_clear_a: assert property (launch && !pick_b && !$changed(pin_sync[0]) // [RULE_18]
        |=> a_det == 2'h0 && a_ovr == 2'h0) else $error("channel A flags not released at launch");
    launch_clear_b_a: assert property (launch && pick_b && !$changed(pin_sync[1]) // [RULE_18]
        |=> b_det == 2'h0 && b_ovr == 2'h0) else $error("channel B flags not released at launch");
    other_pace_a: assert property (OTHER_PACKET |=> !launch && budget_ff == RATE_LAST) // [RULE_12]
        else $error("other packet did not restart budget");

    launch_a_c: cover property (launch && !pick_b);
    launch_b_c: cover property (launch && pick_b);
    overrun_c: cover property (launch && |flags_now[7:4]);
    wrap_c: cover property (tick && run && stamp_ff == 24'hffffff);
    both_pend_c: cover property (launch && pend_a && pend_b);
endmodule

// [verification/dect_host_model.sv]
`timescale 1ns/1ps
module dect_host_model import dect_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic rep_valid,
    input wire logic [7:0] rep_id,
    input wire logic [7:0] rep_flags,
    input wire logic [47:0] rep_bytes,
    output logic rep_ready,
    output logic [7:0] got_id,
    output logic [7:0] got_flags,
    output logic [STAMP_W-1:0] got_fall,
    output logic [STAMP_W-1:0] got_rise,
    output int got_count
);
    int wait_cnt;
    // ----------------------------------------
    // Host side of the report path
    // ----------------------------------------
    // Ready raised off the edge, promptly or after a stall of six cycles
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            rep_ready <= 1'b0;
            wait_cnt <= 0;
        end else if (rep_valid && !rep_ready && (!slow || wait_cnt >= 6)) begin
            rep_ready <= 1'b1;
            wait_cnt <= 0;
        end else if (rep_valid && !rep_ready) begin
            wait_cnt <= wait_cnt + 1;
        end else begin
            rep_ready <= 1'b0;
        end
    end
    // Report taken at the edge that sees valid and ready together
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            got_count <= 0;
        end else if (rep_valid && rep_ready) begin
            got_id <= rep_id;
            got_flags <= rep_flags;
            got_fall <= rep_bytes[23:0]; // First byte is the low byte
            got_rise <= rep_bytes[47:24];
            got_count <= got_count + 1;
        end
    end
endmodule

// [verification/dect_top_tb_top.sv]
`timescale 1ns/1ps
module dect_top_tb_top import dect_pkg::*; ();
    localparam int RC = 400;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] pins = 2'h0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_id = 8'h00;
    logic [7:0] cmd_en = 8'h00;
    logic other_pkt = 1'b0;
    logic slow = 1'b0;
    logic ready, rvalid;
    logic [7:0] rid, rflags, fl, fm, fh, rl, rm, rh, got_id, got_flags;
    logic [1:0] chan_en;
    logic [23:0] timebase, got_fall, got_rise, lo1, hi1, lo2, hi2, keep;
    int got_count, mark;
    int cyc = 0;
    int err_total = 0;
    int samples_checked = 0;
    // ----------------------------------------
    // Design, host model, clock
    // ----------------------------------------
    dect_top #(.RATE_CYCLES(RC)) dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .CAPTURE_A_PIN(pins[0]),
        .CAPTURE_B_PIN(pins[1]), .CMD_VALID(cmd_valid), .CMD_ID(cmd_id), .CMD_ENABLE(cmd_en),
        .OTHER_PACKET(other_pkt), .REPORT_READY(ready), .REPORT_VALID(rvalid), .REPORT_ID(rid),
        .REPORT_FLAGS(rflags), .FALLING_STAMP_LOW_BYTE(fl), .FALLING_STAMP_MID_BYTE(fm),
        .FALLING_STAMP_HIGH_BYTE(fh), .RISING_STAMP_LOW_BYTE(rl), .RISING_STAMP_MID_BYTE(rm),
        .RISING_STAMP_HIGH_BYTE(rh), .CHANNEL_ENABLE(chan_en), .TIMEBASE(timebase));
    dect_host_model host_u (.clk(clock), .rst(sys_rst), .slow(slow), .rep_valid(rvalid), .rep_id(rid),
        .rep_flags(rflags), .rep_bytes({rh, rm, rl, fh, fm, fl}), .rep_ready(ready), .got_id(got_id),
        .got_flags(got_flags), .got_fall(got_fall), .got_rise(got_rise), .got_count(got_count));
    initial begin
        forever #25 clock = ~clock;
    end
    // Cycle count and hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_stamp(input logic [23:0] got, input logic [23:0] lo, input logic [23:0] hi);
        samples_checked++;
        if (got !== lo && got !== hi) begin
            err_total++;
            $display("MISMATCH at %0t: stamp %0h expected %0h or %0h", $time, got, lo, hi);
        end
    endtask
    task automatic send_cmd(input logic [7:0] id, input logic [7:0] en);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_id = id;
        cmd_en = en;
        @(negedge clock);
        cmd_valid = 1'b0;
        @(negedge clock);
    endtask
    // Moves the masked pins, brackets the timebase around the edge
    task automatic drive_pins(input logic [1:0] msk, input logic [1:0] v,
                              output logic [23:0] lo, output logic [23:0] hi);
        @(negedge clock);
        lo = timebase;
        pins = (pins & ~msk) | (v & msk);
        repeat (4) @(negedge clock);
        hi = timebase;
    endtask
    task automatic wait_report();
        int n0;
        int k;
        n0 = got_count;
        k = 0;
        while (got_count == n0 && k < 2000) begin
            @(negedge clock);
            k++;
        end
        check_val(got_count, n0 + 1);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        check_val(chan_en, 0);
        repeat (200) @(negedge clock);
        check_val(timebase, 0); // Holds while disabled
        send_cmd(8'h28, 8'h01);
        check_val(chan_en, 1);
        keep = timebase;
        for (int i = 0; i < 100 && timebase === keep; i++) begin
            @(negedge clock);
        end
        keep = timebase;
        repeat (79) @(negedge clock);
        check_val(timebase, keep);
        @(negedge clock);
        check_val(timebase, keep + 1); // One step per 80 cycles
        // Single rising edge on A
        drive_pins(2'h1, 2'h1, lo1, hi1);
        wait_report();
        mark = cyc;
        check_val(got_id, ID_REPORT_A);
        check_val(got_flags, 8'h02);
        check_stamp(got_rise, lo1, hi1);
        // Fall, rise, fall again inside one budget window
        drive_pins(2'h1, 2'h0, lo1, hi1);
        repeat (95) @(negedge clock);
        drive_pins(2'h1, 2'h1, lo2, hi2);
        repeat (95) @(negedge clock);
        drive_pins(2'h1, 2'h0, keep, keep);
        wait_report();
        check_val(cyc - mark >= RC, 1);
        mark = cyc;
        check_val(got_flags, 8'h13); // Fall overrun plus both detects
        check_stamp(got_fall, lo1, hi1); // First fall kept
        check_stamp(got_rise, lo2, hi2);
        // Both channels, slow host
        send_cmd(8'h28, 8'h00); // Disable before the new combination
        check_val(chan_en, 0);
        send_cmd(8'h27, 8'h03);
        check_val(chan_en, 0); // Foreign id ignored
        send_cmd(8'h28, 8'h03);
        check_val(chan_en, 3);
        slow = 1'b1;
        drive_pins(2'h3, 2'h3, lo1, hi1);
        wait_report();
        mark = cyc;
        keep = got_rise;
        check_val(got_id, ID_REPORT_B);
        check_val(got_flags, 8'h0a); // Flags of both channels
        check_stamp(got_rise, lo1, hi1);
        wait_report();
        check_val(cyc - mark >= RC, 1);
        check_val(got_id, ID_REPORT_A);
        check_val(got_flags, 8'h02);
        check_val(got_rise, keep); // Same shared counter
        // Packet of another function restarts the budget; infrared, two-wire, matrix stay idle
        slow = 1'b0;
        repeat (RC) @(negedge clock);
        other_pkt = 1'b1;
        @(negedge clock);
        other_pkt = 1'b0;
        mark = cyc;
        drive_pins(2'h2, 2'h0, lo1, hi1);
        wait_report();
        check_val(cyc - mark >= RC - 1, 1);
        check_val(got_flags, 8'h04);
        check_stamp(got_fall, lo1, hi1);
        tally_and_finish();
    end
endmodule
